// >>> dv/measurement_store_error_log_tb.sv
// Purpose: Self-checking bench for the store and error log block
// Assumes: Store depth shrunk to 4 so fills are short
// Notes:   Codes and data are random from a fixed seed
module measurement_store_error_log_tb import msel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 4; // Shrunk store depth
  localparam int CW = 3; // Count width for D
  logic i_clk, i_arst_n, i_nv_arst_n, i_store_en_set, i_store_en_val;
  logic i_store_mode_set, i_set_store_count_cmd, i_panel_clear;
  logic i_memory_clear_cmd, i_sweep_mode, i_sweep_running, i_sweep_start;
  logic i_event_clear, i_meas_valid, o_meas_ready, o_wr_valid, i_wr_ready;
  logic o_store_indicator, o_meas_halt, o_sweep_stop, o_store_on;
  logic o_cmd_rejected, i_err_valid, i_log_displayed, i_error_log_query;
  logic i_clear_status_cmd, o_err_pending, o_log_valid, o_hist_valid;
  logic i_error_history_query, o_hist_last, i_hist_ready, stop_seen;
  logic [CW-1:0] i_store_count_val, o_wr_addr, o_store_count;
  logic [31:0] i_meas_data, o_wr_data;
  logic [15:0] o_dev_event_status; // Event bits
  msel_mode_t i_store_mode_val, o_store_mode;
  logic signed [10:0] i_err_code, o_hist_data;
  logic [4:0][10:0] o_log_data;
  logic [2:0] o_log_count;
  int miscompares, tests_run, cyc, sink_n, sink_bad, n0;
  logic signed [10:0] hq[$], lq[$]; // Expected history and log
  msel_top #(.DEPTH(D)) DUT (.*);
  msel_store_sink #(.CW(CW)) sink (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_valid(o_wr_valid), .i_addr(o_wr_addr), .o_ready(i_wr_ready),
    .i_data(o_wr_data), .i_exp(i_meas_data),
    .o_writes(sink_n), .o_bad(sink_bad));
  // ----------------------------------------------------------------
  // Clock, host stall, watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end
  // Random host stall and sweep stop latch; ceiling far above the run
  always @(posedge i_clk) begin
    i_hist_ready <= $urandom % 2;
    if (o_sweep_stop === 1'h1) stop_seen <= 1'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Drop all strobes at the taking edge, then let the answer land
  task automatic step();
    @(posedge i_clk) {i_store_en_set, i_store_mode_set, i_panel_clear,
      i_set_store_count_cmd, i_memory_clear_cmd, i_sweep_start,
      i_event_clear, i_err_valid, i_log_displayed, i_error_log_query,
      i_clear_status_cmd, i_error_history_query} <= '0;
    #1;
  endtask
  task automatic err(input logic signed [10:0] c);
    @(posedge i_clk) begin
      i_err_valid <= 1'h1;
      i_err_code <= c;
    end
    step();
    hq.push_back(c);
    if (hq.size() > 10) void'(hq.pop_front());
    if (lq.size() == 5) lq[4] = c;
    else lq.push_back(c);
  endtask
  // Offer results until full, then keep offering; extras must be dropped
  task automatic fill(input logic burst);
    n0 = sink_n;
    // One random word per fill, so the sink can check every write
    @(posedge i_clk) begin
      i_meas_valid <= 1'h1;
      i_meas_data <= $urandom;
    end
    for (int k = 0; k < 100 && o_store_indicator !== 1'h1; k++) begin
      @(posedge i_clk);
      #1;
    end
    for (int k = 0; k < 100 && sink_n - n0 < D; k++) @(posedge i_clk);
    repeat (7) @(posedge i_clk);
    @(posedge i_clk) i_meas_valid <= 1'h0;
    #1;
    chk(o_store_count, D);
    chk(sink_n - n0, D);
    chk(o_store_indicator, 1);
    chk(o_dev_event_status[10], 1);
    chk(o_dev_event_status[4], 1);
    chk(o_meas_halt, burst);
  endtask
  // Collect a full history reply under the random host stall
  task automatic hist();
    int n;
    n = 0;
    @(posedge i_clk) i_error_history_query <= 1'h1;
    step();
    for (int k = 0; k < 100 && n < 10; k++) begin
      @(posedge i_clk);
      if (o_hist_valid === 1'h1 && i_hist_ready === 1'h1) begin
        chk(o_hist_data, hq[n]);
        chk(o_hist_last, n == 9);
        n++;
      end
    end
    chk(n, 10);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(26206));
    {i_arst_n, i_nv_arst_n, i_store_en_val, i_meas_valid, i_sweep_mode,
      i_sweep_running, i_hist_ready, stop_seen, i_meas_data, i_err_code,
      i_store_count_val, cyc, miscompares, tests_run} = '0;
    i_store_mode_val = MSEL_MODE_NORMAL;
    step();
    repeat (11) @(posedge i_clk);
    {i_arst_n, i_nv_arst_n} <= 2'h3;
    #1;
    chk(o_meas_ready, 1);
    chk(o_dev_event_status, 0);
    chk(o_err_pending, 0);
    @(posedge i_clk) begin
      {i_set_store_count_cmd, i_store_en_set, i_store_en_val} <= 3'h7;
      i_store_count_val <= 3'h3;
    end
    step();
    chk(o_store_on, 1);
    // Settings refused while a source sweep runs
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk) begin
        {i_sweep_mode, i_sweep_running, i_store_en_val} <= 3'h6;
        i_store_mode_val <= MSEL_MODE_BURST;
        if (j == 0) i_store_en_set <= 1'h1;
        else i_store_mode_set <= 1'h1;
      end
      step();
      chk(o_cmd_rejected, 1);
      chk(o_store_on, 1);
      chk(o_store_mode, MSEL_MODE_NORMAL);
    end
    @(posedge i_clk) {i_sweep_running, i_store_en_val} <= 2'h1;
    // Each clearing event empties a full buffer
    for (int k = 0; k < 4; k++) begin
      fill(1'h0);
      @(posedge i_clk) begin
        i_event_clear <= 1'h1;
        case (k)
          0: i_panel_clear <= 1'h1;
          1: i_memory_clear_cmd <= 1'h1;
          2: i_store_en_set <= 1'h1;
          default: i_store_mode_set <= 1'h1;
        endcase
      end
      step();
      chk(o_store_count, 0);
      chk(o_dev_event_status, 0);
      if (k == 3) chk(o_store_mode, MSEL_MODE_BURST);
    end
    fill(1'h1);
    chk(stop_seen, 1);
    @(posedge i_clk) i_sweep_start <= 1'h1;
    step();
    chk(o_store_count, 0);
    // Error log: overflow, query, display
    for (int i = 0; i < 6; i++) err(11'(int'($urandom_range(1998)) - 999));
    chk(o_err_pending, 1);
    @(posedge i_clk) i_error_log_query <= 1'h1;
    step();
    chk(o_log_valid, 1);
    chk(o_log_count, 5);
    for (int i = 0; i < 5; i++) chk($signed(o_log_data[i]), lq[i]);
    chk(o_err_pending, 0);
    lq.delete();
    err(-11'sh1);
    @(posedge i_clk) i_log_displayed <= 1'h1;
    step();
    chk(o_err_pending, 0);
    for (int i = 0; i < 6; i++) err(11'(int'($urandom_range(1998)) - 999));
    @(posedge i_clk) i_clear_status_cmd <= 1'h1;
    step();
    chk(o_err_pending, 0);
    hist();
    // Power-on clears the log, the history survives
    fill(1'h1);
    err(11'(int'($urandom_range(1998)) - 999));
    chk(o_err_pending, 1);
    @(posedge i_clk) i_arst_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'h1;
    #1;
    chk(o_err_pending, 0);
    chk(o_store_count, 0);
    hist();
    chk(sink_bad, 0);
    final_report();
  end
endmodule // measurement_store_error_log_tb

// >>> dv/msel_store_sink.sv
// Purpose: Store memory model behind the write port
// Assumes: One clock, reset shared with the block
// Notes:   Stalls one cycle in three to exercise the buffer
module msel_store_sink #(
  parameter int CW = 3 // Slot width
) (
  input wire logic i_clk, // Clock
  input wire logic i_arst_n, // Reset, low
  input wire logic i_valid, // Write offered
  input wire logic [CW-1:0] i_addr, // Write slot
  input wire logic [31:0] i_data, // Write data
  input wire logic [31:0] i_exp, // Word the bench offered
  output logic o_ready, // Write taken
  output int o_writes, // Writes taken
  output int o_bad // Slots out of order or data not matching the offer
);
  logic [CW-1:0] last; // Slot of previous write
  // Random stall; slots run 0, 1, 2 and data matches the offer
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'h0;
      o_writes <= 0;
      o_bad <= 0;
      last <= '0;
    end else begin
      o_ready <= ($urandom % 3) != 0;
      if (i_valid && o_ready) begin
        o_writes <= o_writes + 1;
        if ((i_addr != 0 && i_addr != last + 1'h1) || i_data !== i_exp)
          o_bad <= o_bad + 1;
        last <= i_addr;
      end
    end
  end
endmodule // msel_store_sink

// >>> src/msel_buf2.sv
// Purpose: Two-entry buffer between measurement source and store memory
// Assumes: One clock, asynchronous active-low reset
// Notes:   All outputs come from flops; flush drops both entries
module msel_buf2 #(
  parameter int W = 8 // Word width
) (
  input wire logic i_clk, // Clock
  input wire logic i_arst_n, // Async reset, low
  input wire logic i_flush, // Drop all entries
  input wire logic i_valid, // Source word valid
  input wire logic [W-1:0] i_data, // Source word
  output logic o_ready, // Room for a word
  output logic o_valid, // Head word valid
  output logic [W-1:0] o_data, // Head word
  input wire logic i_ready // Sink takes head
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] q0; // Head
    logic [W-1:0] q1; // Second
    logic v0; // Head valid
    logic v1; // Second valid
    logic room; // Ready kept in a flop, not inverted
  } msel_buf_st_t;
  msel_buf_st_t s; // Registered state
  msel_buf_st_t next_s; // Next state
  // Pop first, then push into the lowest free entry
  always_comb begin
    next_s = s;
    if (s.v0 && i_ready) begin
      next_s.q0 = s.q1;
      next_s.v0 = s.v1;
      next_s.v1 = 1'h0;
    end
    // Ready is !v1, so a push never finds both entries taken
    if (i_valid && !s.v1) begin
      if (!next_s.v0) begin
        next_s.q0 = i_data;
        next_s.v0 = 1'h1;
      end else begin
        next_s.q1 = i_data;
        next_s.v1 = 1'h1;
      end
    end
    if (i_flush) begin
      next_s = '0;
    end
    next_s.room = !next_s.v1;
  end
  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{default: '0, room: 1'h1};
    end else begin
      s <= next_s;
    end
  end
  assign o_ready = s.room;
  assign o_valid = s.v0;
  assign o_data = s.q0;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_buf_hold_head: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s.v0 && !i_ready && !i_flush |=> s.v0 && $stable(s.q0))
    else $error("buffer head changed while stalled");
endmodule // msel_buf2

// >>> src/msel_err_hist.sv
// Purpose: Ten-entry retained error history with ordered readback
// Assumes: i_nv_arst_n is the retention domain reset, not power-on
// Notes:   Appends during a reply shift entries not yet sent
`include "msel_regs.svh"
module msel_err_hist
  import msel_pkg::*;
#(
  parameter int HS = `MSEL_HIST_SLOTS, // History entries
  parameter int EW = `MSEL_ERR_W // Error number width
) (
  input wire logic i_clk, // Clock
  input wire logic i_nv_arst_n, // Retention reset, low
  input wire logic i_err_valid, // New error
  input wire logic signed [EW-1:0] i_err_code, // Error number
  input wire logic i_query, // History query
  output logic o_valid, // Reply entry valid
  output logic signed [EW-1:0] o_data, // Reply entry
  output logic o_last, // Newest entry
  input wire logic i_ready // Host takes entry
);
  localparam int IW = $clog2(HS); // Index width
  typedef struct packed {
    logic [HS-1:0][EW-1:0] slot; // Index 0 oldest
    msel_hist_state_t st; // Reply state
    logic [IW-1:0] idx; // Entry on output
    logic valid; // Output valid
    logic [EW-1:0] data; // Output entry
    logic last; // Output is newest
  } msel_hist_st_t;
  msel_hist_st_t s; // Registered state
  msel_hist_st_t next_s; // Next state
  // ----------------------------------------------------------------
  // Append and reply
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Oldest drops out, newest lands at top slot
    if (i_err_valid) begin
      next_s.slot = {i_err_code, s.slot[HS-1:1]};
    end
    unique case (s.st)
      MSEL_HIST_IDLE: begin
        if (i_query) begin
          next_s.st = MSEL_HIST_SEND;
          next_s.idx = '0;
          next_s.data = s.slot[0];
          next_s.valid = 1'h1;
          next_s.last = (HS == 1);
        end
      end
      MSEL_HIST_SEND: begin
        if (i_ready && s.last) begin
          next_s.valid = 1'h0;
          next_s.last = 1'h0;
          next_s.st = MSEL_HIST_IDLE;
        end else if (i_ready) begin
          next_s.idx = s.idx + 1'h1;
          next_s.data = s.slot[next_s.idx];
          next_s.last = (next_s.idx == IW'(HS - 1));
        end
      end
      default: begin
        next_s.st = MSEL_HIST_IDLE;
        next_s.valid = 1'h0;
      end
    endcase
  end
  // Only the retention reset clears it; log clears never reach here
  always_ff @(posedge i_clk or negedge i_nv_arst_n) begin
    if (!i_nv_arst_n) begin
      s <= '{default: '0, st: MSEL_HIST_IDLE};
    end else begin
      s <= next_s;
    end
  end
  assign o_valid = s.valid;
  assign o_data = s.data;
  assign o_last = s.last;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hist_shift_in: assert property (
    @(posedge i_clk) disable iff (!i_nv_arst_n)
    i_err_valid |=> s.slot[HS-1] == $past(i_err_code)
      && s.slot[HS-2] == $past(s.slot[HS-1]))
    else $error("history append lost order");
  a_hist_reply_len: assert property (
    @(posedge i_clk) disable iff (!i_nv_arst_n)
    s.valid && i_ready && !s.last |=> s.valid
      && s.idx == $past(s.idx) + 1'h1)
    else $error("history reply skipped an entry");
  c_hist_last: cover property (@(posedge i_clk) disable iff (!i_nv_arst_n)
    s.valid && s.last && i_ready);
endmodule // msel_err_hist

// >>> src/msel_pkg.sv
// Purpose: Types shared by the measurement store and error log block
// Assumes: msel_regs.svh holds the numbers
// Notes:   One-hot state codes are written out
package msel_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // History reply sequencer
  typedef enum logic [1:0] {
    MSEL_HIST_IDLE = 2'h1,
    MSEL_HIST_SEND = 2'h2
  } msel_hist_state_t;
  // Store mode as seen on the mode port
  typedef enum logic {
    MSEL_MODE_NORMAL = 1'h0,
    MSEL_MODE_BURST = 1'h1
  } msel_mode_t;
endpackage

// >>> src/msel_regs.svh
// Purpose: Named constants of the measurement store and error log block
// Assumes: Included by msel_err_hist and msel_top
// Notes:   Definitions only
`ifndef MSEL_REGS_SVH
`define MSEL_REGS_SVH
// ----------------------------------------------------------------
// Device event status layout
// ----------------------------------------------------------------
`define MSEL_STATUS_W 16
`define MSEL_MEM_FULL_BIT 10
`define MSEL_CNT_REACHED_BIT 4
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MSEL_STORE_DEPTH 20000
`define MSEL_LOG_SLOTS 5
`define MSEL_HIST_SLOTS 10
`define MSEL_ERR_W 11
`define MSEL_MEAS_W 32
`endif

// >>> src/msel_top.sv
// Purpose: Measurement store control, error log and error history
// Assumes: Single 125 MHz clock; strobes are one-cycle pulses
// Notes:   Store memory sits outside; this block feeds its write port
// ----------------------------------------------------------------
// How it works
// - Full buffer sets event bit and indicator
// - Normal stops writing; burst halts and stops sweep
// - Count equals target sets count-reached event bit
// - Store on/off and mode changes refused during source sweep
// - Clears, enables, mode switches and power-on empty buffer
// - Burst mode empties buffer at sweep start
// - Errors fill five log slots in order
// - Sixth error overwrites the last slot
// - Pending indicator follows non-empty log
// - Log cleared by power-on, display, query, clear-status
// - Ten-entry history survives power-on and log clears
// - History drops oldest, newest in slot ten
// - History query returns oldest to newest
// ----------------------------------------------------------------
`include "msel_regs.svh"
module msel_top
  import msel_pkg::*;
#(
  parameter int DEPTH = `MSEL_STORE_DEPTH, // Store capacity
  parameter int MW = `MSEL_MEAS_W, // Result width
  parameter int LS = `MSEL_LOG_SLOTS, // Log slots
  parameter int HS = `MSEL_HIST_SLOTS, // History slots
  parameter int EW = `MSEL_ERR_W, // Error number width
  parameter int CW = $clog2(DEPTH + 1) // Count width
) (
  input wire logic i_clk, // Clock, 125 MHz
  input wire logic i_arst_n, // Power-on reset, low
  input wire logic i_nv_arst_n, // History retention reset
  // Store settings
  input wire logic i_store_en_set, // Store on/off request
  input wire logic i_store_en_val, // 1 = store on
  input wire logic i_store_mode_set, // Mode change request
  input wire msel_mode_t i_store_mode_val, // Requested mode
  input wire logic i_set_store_count_cmd, // Load target
  input wire logic [CW-1:0] i_store_count_val, // Target count
  input wire logic i_panel_clear, // Panel memory clear
  input wire logic i_memory_clear_cmd, // Remote memory clear
  input wire logic i_sweep_mode, // Sweep source mode
  input wire logic i_sweep_running, // Sweep in progress
  input wire logic i_sweep_start, // Sweep starts
  input wire logic i_event_clear, // Event register read
  // Measurement stream
  input wire logic i_meas_valid, // Result valid
  input wire logic [MW-1:0] i_meas_data, // Result
  output logic o_meas_ready, // Buffer room
  output logic o_wr_valid, // Store write valid
  output logic [CW-1:0] o_wr_addr, // Store write slot
  output logic [MW-1:0] o_wr_data, // Store write data
  input wire logic i_wr_ready, // Store memory takes
  // Store status
  output logic [`MSEL_STATUS_W-1:0] o_dev_event_status, // Events
  output logic o_store_indicator, // Buffer full lamp
  output logic o_meas_halt, // Burst halt level
  output logic o_sweep_stop, // Sweep stop pulse
  output logic o_store_on, // Storing enabled
  output msel_mode_t o_store_mode, // Current mode
  output logic [CW-1:0] o_store_count, // Results stored
  output logic o_cmd_rejected, // Setting refused pulse
  // Error log
  input wire logic i_err_valid, // Error detected
  input wire logic signed [EW-1:0] i_err_code, // Error number
  input wire logic i_log_displayed, // Log screen shown
  input wire logic i_error_log_query, // Log query
  input wire logic i_clear_status_cmd, // Clear-status command
  output logic o_err_pending, // Error indicator
  output logic o_log_valid, // Log reply pulse
  output logic [LS-1:0][EW-1:0] o_log_data, // Slot 0 first
  output logic [$clog2(LS+1)-1:0] o_log_count, // Slots in reply
  // Error history
  input wire logic i_error_history_query, // History query
  output logic o_hist_valid, // Entry valid
  output logic signed [EW-1:0] o_hist_data, // Entry
  output logic o_hist_last, // Newest entry
  input wire logic i_hist_ready // Host takes entry
);
  // ----------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------
  localparam int LCW = $clog2(LS + 1); // Log count width
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH); // Full mark
  localparam logic [LCW-1:0] LOG_MAX = LCW'(LS); // Log full mark
  typedef struct packed {
    logic store_on; // Storing enabled
    logic burst; // Burst mode
    logic [CW-1:0] target; // Host target count
    logic [CW-1:0] count; // Results taken
    logic mem_full; // Buffer full level
    logic halt; // Burst halt
    logic sweep_stop; // Stop pulse
    logic reject; // Refusal pulse
    logic [`MSEL_STATUS_W-1:0] evt; // Sticky events
    logic [LS-1:0][EW-1:0] log; // Error log slots
    logic [LCW-1:0] log_cnt; // Slots used
    logic pending; // Indicator
    logic log_vld; // Reply pulse
    logic [LS-1:0][EW-1:0] log_out; // Reply copy
    logic [LCW-1:0] log_out_cnt; // Reply count
  } msel_top_st_t;
  msel_top_st_t s; // Registered state
  msel_top_st_t next_s; // Next state
  logic locked; // On/off and mode frozen by sweep
  logic clr; // Empty the buffer now
  logic lclr; // Empty the log now
  logic enq; // Result enters buffer
  logic buf_in_ready; // Buffer room
  logic [CW-1:0] cnt_inc; // Count after enqueue
  // ----------------------------------------------------------------
  // Clear and accept decisions
  // ----------------------------------------------------------------
  // On/off and mode changes are frozen while a source sweep runs
  assign locked = i_sweep_mode && i_sweep_running;
  // Any accepted enable-on or mode switch also empties the buffer
  assign clr = i_panel_clear || i_memory_clear_cmd
    || (s.burst && i_sweep_start)
    || (!locked && i_store_en_set && i_store_en_val)
    || (!locked && i_store_mode_set
        && (i_store_mode_val != msel_mode_t'(s.burst)));
  assign lclr = i_log_displayed || i_error_log_query
    || i_clear_status_cmd;
  // A full buffer takes nothing more; measuring carries on in normal mode
  assign enq = i_meas_valid && buf_in_ready && s.store_on
    && !s.mem_full && !s.halt && !clr;
  assign cnt_inc = s.count + 1'h1;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sweep_stop = 1'h0;
    next_s.reject = 1'h0;
    next_s.log_vld = 1'h0;
    // Event read clears; a set in the same cycle wins below
    if (i_event_clear) begin
      next_s.evt = '0;
    end
    // Store settings
    if ((i_store_en_set || i_store_mode_set) && locked) begin
      next_s.reject = 1'h1;
    end else begin
      if (i_store_en_set) begin
        next_s.store_on = i_store_en_val;
      end
      if (i_store_mode_set) begin
        next_s.burst = (i_store_mode_val == MSEL_MODE_BURST);
      end
    end
    if (i_set_store_count_cmd) begin
      next_s.target = i_store_count_val;
    end
    // Buffer fill
    if (clr) begin
      next_s.count = '0;
      next_s.mem_full = 1'h0;
      next_s.halt = 1'h0;
    end else if (enq) begin
      next_s.count = cnt_inc;
      if (cnt_inc == FULL_CNT) begin
        next_s.mem_full = 1'h1;
        next_s.evt[`MSEL_MEM_FULL_BIT] = 1'h1;
        if (s.burst) begin
          next_s.halt = 1'h1;
          next_s.sweep_stop = 1'h1;
        end
      end
      if (s.target != '0 && cnt_inc == s.target) begin
        next_s.evt[`MSEL_CNT_REACHED_BIT] = 1'h1;
      end
    end
    // Error log: reply copies the old contents before clearing
    if (i_error_log_query) begin
      next_s.log_out = s.log;
      next_s.log_out_cnt = s.log_cnt;
      next_s.log_vld = 1'h1;
    end
    if (lclr) begin
      next_s.log = '0;
      next_s.log_cnt = '0;
    end
    // An error in a clearing cycle lands in the emptied log
    if (i_err_valid) begin
      if (next_s.log_cnt < LOG_MAX) begin
        next_s.log[next_s.log_cnt] = i_err_code;
        next_s.log_cnt = next_s.log_cnt + 1'h1;
      end else begin
        next_s.log[LS-1] = i_err_code;
      end
    end
    next_s.pending = (next_s.log_cnt != '0);
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-on empties buffer and log; the history is not here
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // ----------------------------------------------------------------
  // Buffer toward the store memory
  // ----------------------------------------------------------------
  // Stall by the store memory backs up to o_meas_ready
  msel_buf2 #(
    .W(CW + MW)
  ) u_buf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_flush(clr),
    .i_valid(enq),
    .i_data({s.count, i_meas_data}),
    .o_ready(buf_in_ready),
    .o_valid(o_wr_valid),
    .o_data({o_wr_addr, o_wr_data}),
    .i_ready(i_wr_ready)
  );
  assign o_meas_ready = buf_in_ready;
  // ----------------------------------------------------------------
  // Retained history
  // ----------------------------------------------------------------
  msel_err_hist #(
    .HS(HS),
    .EW(EW)
  ) u_hist (
    .i_clk(i_clk),
    .i_nv_arst_n(i_nv_arst_n),
    .i_err_valid(i_err_valid),
    .i_err_code(i_err_code),
    .i_query(i_error_history_query),
    .o_valid(o_hist_valid),
    .o_data(o_hist_data),
    .o_last(o_hist_last),
    .i_ready(i_hist_ready)
  );
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_dev_event_status = s.evt;
  assign o_store_indicator = s.mem_full;
  assign o_meas_halt = s.halt;
  assign o_sweep_stop = s.sweep_stop;
  assign o_store_on = s.store_on;
  assign o_store_mode = msel_mode_t'(s.burst);
  assign o_store_count = s.count;
  assign o_cmd_rejected = s.reject;
  assign o_err_pending = s.pending;
  assign o_log_valid = s.log_vld;
  assign o_log_data = s.log_out;
  assign o_log_count = s.log_out_cnt;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_full_sets_flag: assert property (
    enq && cnt_inc == FULL_CNT |=> s.evt[`MSEL_MEM_FULL_BIT]
      && o_store_indicator)
    else $error("full buffer did not raise flag");
  a_full_stops_wr: assert property (
    s.mem_full && !clr |-> !enq ##1 s.count == $past(s.count))
    else $error("write taken into full buffer");
  a_burst_halts: assert property (
    s.burst && enq && cnt_inc == FULL_CNT |=> s.halt && o_sweep_stop
      ##1 !o_sweep_stop && s.halt)
    else $error("burst full did not halt sweep");
  a_count_reached: assert property (
    enq && s.target != '0 && cnt_inc == s.target
      |=> s.evt[`MSEL_CNT_REACHED_BIT])
    else $error("target count not flagged");
  a_locked_refuse: assert property (
    (i_store_en_set || i_store_mode_set) && locked
      |=> o_cmd_rejected && $stable(s.store_on) && $stable(s.burst))
    else $error("setting changed during sweep");
  a_clear_empties: assert property (
    clr |=> s.count == '0 && !s.mem_full && !s.halt)
    else $error("buffer not emptied on clear");
  a_burst_sweep_clr: assert property (
    s.burst && i_sweep_start |=> s.count == '0)
    else $error("burst sweep start kept old data");
  a_log_in_order: assert property (
    i_err_valid && !lclr && s.log_cnt < LOG_MAX
      |=> s.log[$past(s.log_cnt)] == $past(i_err_code)
        && s.log_cnt == $past(s.log_cnt) + 1'h1)
    else $error("error not placed in next slot");
  a_log_overwrite: assert property (
    i_err_valid && !lclr && s.log_cnt == LOG_MAX
      |=> s.log[LS-1] == $past(i_err_code) && s.log_cnt == LOG_MAX)
    else $error("full log did not overwrite last slot");
  a_log_clear_ind: assert property (
    lclr && !i_err_valid |=> !o_err_pending && s.log_cnt == '0)
    else $error("indicator stayed after log clear");
  c_burst_full: cover property (s.burst && o_sweep_stop);
  c_count_hit: cover property ($rose(s.evt[`MSEL_CNT_REACHED_BIT]));
  c_log_over: cover property (i_err_valid && s.log_cnt == LOG_MAX);
  c_wr_stall: cover property (o_wr_valid && !i_wr_ready && !o_meas_ready);
endmodule // msel_top
